// >>> bench/ptgc_clock_unit_assertions.sv
// Checker for the clock unit ports: bus answers and output gating.
// Assumes it is bound onto ptgc_clock_unit and sees only its ports.
module ptgc_clock_unit_assertions (
  // Clock and reset
  input wire logic                CLOCK,
  input wire logic                RST_N,
  // Register bus
  input wire ptgc_pkg::ptgc_req_t REG_REQ,
  input wire logic [7:0]          REG_RDATA,
  input wire logic                REG_RVALID,
  // Decoder clock pin
  input wire logic                DECODER_CLOCK_OUTPUT,
  input wire logic                DECODER_CLOCK_OE_N
);
  timeunit 1ns;
  timeprecision 1ps;
  import ptgc_pkg::*;
  logic       pin_q;
  logic       halt_q;
  logic       src_q;
  logic       tg_q;
  logic [3:0] quiet_q;
  logic       mapped;

  // Address hits one of the four registers
  assign mapped = REG_REQ.addr[11:2] inside {10'h006, 10'h007, 10'h0c0, 10'h0d4};

  // Shadow of the gating bits as software wrote them
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pin_q  <= 1'b0;
      halt_q <= 1'b0;
      src_q  <= 1'b0;
      tg_q   <= 1'b0;
    end else if (REG_REQ.wr) begin
      if (REG_REQ.addr == 12'h018) pin_q <= REG_REQ.wdata[4];
      if (REG_REQ.addr == 12'h019) begin
        halt_q <= REG_REQ.wdata[5];
        src_q  <= REG_REQ.wdata[4];
      end
      if (REG_REQ.addr == 12'h300) tg_q <= REG_REQ.wdata[7];
    end
  end

  // Cycles since the last write, saturating, so pipelines have drained
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) quiet_q <= 4'h0;
    else if (REG_REQ.wr) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  sequence pin_off_s; !pin_q [*6]; endsequence
  sequence pin_on_s;  pin_q [*6];  endsequence
  property still_p(logic b);
    b && quiet_q == 4'hf |=> $stable(DECODER_CLOCK_OUTPUT);
  endproperty

  rvalid_follow_a: assert property (REG_REQ.rd |=> REG_RVALID)
    else $error("read not answered next cycle");
  rvalid_only_a: assert property (!REG_REQ.rd |=> !REG_RVALID)
    else $error("read answer without request");
  unmapped_zero_a: assert property (REG_REQ.rd && !mapped |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  pin_off_a: assert property (pin_off_s |-> DECODER_CLOCK_OE_N)
    else $error("pin driven while disabled");
  pin_on_a: assert property (pin_on_s |-> !DECODER_CLOCK_OE_N)
    else $error("pin not driven while enabled");
  halt_still_a: assert property (still_p(halt_q))
    else $error("output moves while halted");
  src_still_a: assert property (still_p(src_q))
    else $error("output moves with source bypass");
  tg_off_still_a: assert property (still_p(!tg_q))
    else $error("output moves with timing logic off");
endmodule

bind ptgc_clock_unit ptgc_clock_unit_assertions u_chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
  .REG_RVALID(REG_RVALID), .DECODER_CLOCK_OUTPUT(DECODER_CLOCK_OUTPUT),
  .DECODER_CLOCK_OE_N(DECODER_CLOCK_OE_N)
);

// >>> bench/ptgc_clock_unit_tb.sv
// Bench for the clock unit: register byte accesses and clock pin behaviour.
// Assumes the decoder model counts edges on the pin.
module ptgc_clock_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ptgc_pkg::*;
  logic       CLOCK = 1'b0;
  logic       RST_N;
  ptgc_req_t  req;
  logic [7:0] rdata;
  logic       rvalid;
  logic       pin;
  logic       oe_n;
  logic       clr;
  logic [15:0] rises;
  logic [15:0] c0;
  logic [15:0] c1;
  logic       lvl;
  int         n_fail = 0;
  int         checks_done = 0;

  ptgc_clock_unit u_dut (.CLOCK(CLOCK), .RST_N(RST_N), .REG_REQ(req), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .DECODER_CLOCK_OUTPUT(pin), .DECODER_CLOCK_OE_N(oe_n));
  ptgc_decoder_model u_dec (.clk(CLOCK), .clr(clr), .pin_out(pin), .pin_oe_n(oe_n),
    .rises(rises));

  // 200 MHz clock
  always #2.5 CLOCK = ~CLOCK;

  task final_report;
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    #1 req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(posedge CLOCK);
    #1 req.wr = 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge CLOCK);
    #1 req.rd = 1'b1;
    req.addr = a;
    @(posedge CLOCK);
    #1 req.rd = 1'b0;
    cmp1(rvalid, 1'b1);
    cmp8(rdata, e);
  endtask

  // Lets the output pipeline drain before counting, then samples off the edge
  task measure(input int n, output logic [15:0] c);
    repeat (8) @(posedge CLOCK);
    #1 clr = 1'b1;
    @(posedge CLOCK);
    #1 clr = 1'b0;
    repeat (n) @(posedge CLOCK);
    #1;
    c = rises;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    n_fail++;
    final_report;
  end

  initial begin
    req = '0;
    clr = 1'b0;
    RST_N = 1'b0;
    repeat (2) @(posedge CLOCK);
    #1 RST_N = 1'b1;
    // Reset values and an unmapped place
    rd(12'h018, 8'h00);
    rd(12'h01a, 8'h15);
    rd(12'h01b, 8'h0f);
    rd(12'h01c, 8'h00);
    rd(12'h300, 8'h00);
    rd(12'h100, 8'h00);
    cmp1(oe_n, 1'b1);
    // Divider fields hold what was written
    wr(12'h01c, 8'hff);
    rd(12'h01c, 8'hff);
    wr(12'h01c, 8'h00);
    wr(12'h01b, 8'h5a);
    rd(12'h01b, 8'h5a);
    // Parameter refused before the index is set
    wr(12'h350, 8'hca);
    rd(12'h350, 8'h00);
    wr(12'h300, 8'h12);
    wr(12'h350, 8'hca);
    rd(12'h350, 8'hca);
    // PLL skipped and awake, pin and timing logic enabled last
    wr(12'h01a, 8'h16);
    wr(12'h018, 8'h10);
    wr(12'h300, 8'h92);
    measure(400, c0);
    cmp1(c0 >= 16'h0030 && c0 <= 16'h0034, 1'b1);
    cmp1(oe_n, 1'b0);
    // Divider one keeps one tick in four
    wr(12'h019, 8'h01);
    measure(400, c1);
    cmp1(c1 >= 16'h000b && c1 <= 16'h000e, 1'b1);
    // PLL in use: (0+2)/((2+2)*2) gives a quarter rate
    wr(12'h019, 8'h00);
    wr(12'h01b, 8'h00);
    wr(12'h01c, 8'h44);
    wr(12'h01a, 8'h14);
    measure(400, c1);
    cmp1(c1 >= 16'h000b && c1 <= 16'h000e, 1'b1);
    wr(12'h01a, 8'h16);
    // Halt stops the clock; source bypass is checked after the invert checks
    wr(12'h019, 8'h20);
    measure(100, c1);
    cmp8(c1[7:0], 8'h00);
    // Frozen level flips with clock invert and with pixel invert
    lvl = pin;
    wr(12'h018, 8'h12);
    repeat (2) @(posedge CLOCK);
    #1 cmp1(pin, ~lvl);
    wr(12'h018, 8'h10);
    wr(12'h353, 8'h40);
    repeat (2) @(posedge CLOCK);
    #1 cmp1(pin, ~lvl);
    wr(12'h353, 8'h00);
    wr(12'h019, 8'h10);
    measure(100, c1);
    cmp8(c1[7:0], 8'h00);
    wr(12'h019, 8'h00);
    // PLL asleep with no skip gives no clock
    wr(12'h01a, 8'h15);
    measure(100, c1);
    cmp8(c1[7:0], 8'h00);
    wr(12'h01a, 8'h16);
    // Timing logic off stops the clock
    wr(12'h300, 8'h12);
    measure(100, c1);
    cmp8(c1[7:0], 8'h00);
    // Pin disabled floats to its pull-down
    wr(12'h300, 8'h92);
    wr(12'h018, 8'h00);
    measure(100, c1);
    cmp8(c1[7:0], 8'h00);
    cmp1(oe_n, 1'b1);
    final_report;
  end
endmodule

// >>> bench/ptgc_decoder_model.sv
// Video decoder stand-in: counts rising edges seen on the clock pin.
// Assumes the pin has a pull-down and is sampled on the system clock.
module ptgc_decoder_model (
  // Sampling clock and count clear
  input  wire logic        clk,
  input  wire logic        clr,
  // Pin as driven by the unit
  input  wire logic        pin_out,
  input  wire logic        pin_oe_n,
  // Rising edges since clear
  output logic [15:0]      rises
);
  timeunit 1ns;
  timeprecision 1ps;
  logic level;
  logic prev = 1'b0;

  // Undriven pin falls to its pull-down level
  assign level = pin_oe_n ? 1'b0 : pin_out;

  // Edge counter
  always @(posedge clk) begin
    prev <= level;
    if (clr) rises <= 16'h0000;
    else if (level && !prev) rises <= rises + 16'h0001;
  end
endmodule

// >>> verilog/ptgc_clock_unit.sv
// PLL and timing-generator clock unit with the decoder clock output pin.
// Assumes an 8-bit byte-addressed register bus, reads answered one cycle later.
//
// How it works
// - Divider zero passes clock; else divide by twice the value plus two.
// - Halt bit set stops the timing generator clock.
// - Source bypass clear takes PLL clock; set stops timing generator clock.
// - PLL rate is transceiver clock times (fb+2) over (pre+2) times factor.
// - Post-divider codes 0..3 give factors 1..4.
// - Feedback divider nine bits: low byte select bits 31:24, bit 8 fine bit 0.
// - Fine bits 5:1 pre-detector divider, bits 7:6 post-divider code.
// - PLL output gate bit zero enables output, one disables it.
// - Sleep bit powers down the PLL; resets to one.
// - Clock pin driven only while pin-enable bit is one.
// - Invert bit inverts the output clock.
// - Timing logic runs only while control bit 7 is one.
// - Parameter bit 31 inverts positive-edge pulse.
// - Parameter bit 30 inverts pixel signal polarity.
// - Parameter bit 29 picks OR or AND combining of pulses.
// - Parameter bits 11:9 pick output delay 0..14 ns; applied rounded up to whole 5 ns clock cycles, 0..15 ns.
// - Parameter bits 8:6 set pixel counter total per pixel.
// - Bits 5:3 decode negative-edge pulse from pixel count.
// - Bits 2:0 decode positive-edge pulse from pixel count.
module ptgc_clock_unit (
  // Clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RST_N,
  // Register bus
  input  wire ptgc_pkg::ptgc_req_t REG_REQ,
  output logic [7:0]      REG_RDATA,
  output logic            REG_RVALID,
  // Decoder clock output pin
  output logic            DECODER_CLOCK_OUTPUT,
  output logic            DECODER_CLOCK_OE_N
);
  import ptgc_pkg::*;

  logic [31:0]    select_q;
  logic [31:0]    fine_q;
  logic [31:0]    tgctl_q;
  logic [31:0]    param_q;
  ptgc_pll_cfg_t  pll_cfg;
  logic           pll_tick;
  logic           tg_tick;
  logic           tg_run;
  logic           pos_q;
  logic           neg_q;
  logic           ph_q;
  logic [2:0]     pix_q;
  logic [2:0]     dly_cyc;
  logic           shaped;
  logic [7:0]     dly_line_q;
  ptgc_tg_state_t st_q;
  logic [1:0]     lane;
  logic [11:0]    base;

  assign lane = REG_REQ.addr[1:0];
  assign base = {REG_REQ.addr[11:2], 2'b00};

  // Register writes: one byte lane per request
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      select_q <= PTGC_RST_SELECT;
      fine_q   <= PTGC_RST_FINE;
      tgctl_q  <= PTGC_RST_TGCTL;
      param_q  <= PTGC_RST_PARAM;
    end else if (REG_REQ.wr) begin
      case (base)
        PTGC_OFS_SELECT: select_q[lane*8 +: 8] <= REG_REQ.wdata;
        PTGC_OFS_FINE:   fine_q[lane*8 +: 8]   <= REG_REQ.wdata;
        PTGC_OFS_TGCTL:  tgctl_q[lane*8 +: 8]  <= REG_REQ.wdata;
        PTGC_OFS_PARAM: begin
          // Parameters land only for the clock-output index
          if (tgctl_q[PTGC_B_IDX_HI:0] == PTGC_IDX_CLOCK_OUT) begin
            param_q[lane*8 +: 8] <= REG_REQ.wdata;
          end
        end
        default: ;
      endcase
    end
  end

  // Register reads, one cycle later; unmapped reads give zero
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_REQ.rd;
      case (base)
        PTGC_OFS_SELECT: REG_RDATA <= select_q[lane*8 +: 8];
        PTGC_OFS_FINE:   REG_RDATA <= fine_q[lane*8 +: 8];
        PTGC_OFS_TGCTL:  REG_RDATA <= tgctl_q[lane*8 +: 8];
        PTGC_OFS_PARAM:  REG_RDATA <= param_q[lane*8 +: 8];
        default:         REG_RDATA <= 8'h00;
      endcase
    end
  end

  // PLL configuration assembly
  always_comb begin
    pll_cfg.fb_div    = {fine_q[PTGC_B_FB_HIGH],
                         select_q[PTGC_B_FB_LOW_HI:PTGC_B_FB_LOW_LO]};
    pll_cfg.pre_div   = fine_q[PTGC_B_PRE_HI:PTGC_B_PRE_LO];
    pll_cfg.post_code = fine_q[PTGC_B_POST_HI:PTGC_B_POST_LO];
  end

  // PLL rate generation
  ptgc_pll_model u_pll (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .cfg   (pll_cfg),
    .sleep (select_q[PTGC_B_PLL_SLEEP]),
    .skip  (select_q[PTGC_B_PLL_SKIP]),
    .gate  (select_q[PTGC_B_OUT_GATE]),
    .tick  (pll_tick)
  );

  // Timing clock runs unless halted, bypassed, or logic disabled
  assign tg_run = !select_q[PTGC_B_TG_HALT] && !select_q[PTGC_B_TG_SKIP]
                  && (st_q != PTGC_TG_OFF);

  ptgc_tg_divider #(.W(4)) u_tgdiv (
    .clk      (CLOCK),
    .rst_n    (RST_N),
    .divide   (select_q[PTGC_B_TG_DIV_HI:PTGC_B_TG_DIV_LO]),
    .run      (tg_run),
    .src_tick (pll_tick),
    .tg_tick  (tg_tick)
  );

  // Timing logic enable sequencing
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= PTGC_TG_OFF;
    end else begin
      case (st_q)
        PTGC_TG_OFF: if (tgctl_q[PTGC_B_TG_EN]) st_q <= PTGC_TG_ARM;
        PTGC_TG_ARM: st_q <= tgctl_q[PTGC_B_TG_EN] ? PTGC_TG_RUN : PTGC_TG_OFF;
        PTGC_TG_RUN: if (!tgctl_q[PTGC_B_TG_EN]) st_q <= PTGC_TG_OFF;
        default:     st_q <= PTGC_TG_OFF;
      endcase
    end
  end

  // Pulse decode from a pixel count
  function automatic logic decode(input logic [2:0] code, input logic [2:0] cnt);
    logic hit;
    hit = 1'b0;
    case (code)
      PTGC_PD_LOW:  hit = 1'b0;
      PTGC_PD_EQ01: hit = (cnt <= 3'h1);
      PTGC_PD_LT8:  hit = (cnt <= PTGC_CNT_LT8);
      3'h6:         hit = 1'b0;
      default:      hit = (cnt == code - 3'h1);
    endcase
    return hit;
  endfunction

  // Pixel counter and half-phase; positive half then negative half, one timing tick each
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pix_q <= 3'h0;
      ph_q  <= 1'b0;
    end else if (!tg_run) begin
      pix_q <= 3'h0;
      ph_q  <= 1'b0;
    end else if (tg_tick) begin
      ph_q <= ~ph_q;
      if (ph_q) begin
        pix_q <= (pix_q >= param_q[PTGC_B_TOT_HI:PTGC_B_TOT_LO]) ? 3'h0 : pix_q + 3'h1;
      end
    end
  end

  // Edge pulses registered on their own half-phase
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end else if (tg_tick && !ph_q) begin
      pos_q <= decode(param_q[PTGC_B_POSD_HI:PTGC_B_POSD_LO], pix_q)
               ^ param_q[PTGC_B_POS_INV];
    end else if (tg_tick && ph_q) begin
      neg_q <= decode(param_q[PTGC_B_NEG_HI:PTGC_B_NEG_LO], pix_q);
    end
  end

  // Combine, polarity and delay selection
  always_comb begin
    shaped = param_q[PTGC_B_AND_MODE] ? (pos_q & neg_q) : (pos_q | neg_q);
    shaped = shaped ^ param_q[PTGC_B_PIX_INV];
    dly_cyc = 3'((PTGC_DLY_NS[param_q[PTGC_B_DLY_HI:PTGC_B_DLY_LO]]
                  + PTGC_CLK_PERIOD_NS - 1) / PTGC_CLK_PERIOD_NS);
  end

  // Delay line in whole clock cycles
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      dly_line_q <= 8'h00;
    end else begin
      dly_line_q <= {dly_line_q[6:0], shaped};
    end
  end

  // Output pin: inversion and drive enable
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      DECODER_CLOCK_OUTPUT <= 1'b0;
      DECODER_CLOCK_OE_N   <= 1'b1;
    end else begin
      DECODER_CLOCK_OUTPUT <= (dly_cyc == 3'h0 ? shaped : dly_line_q[dly_cyc - 3'h1])
                              ^ select_q[PTGC_B_INVERT];
      DECODER_CLOCK_OE_N   <= !select_q[PTGC_B_PIN_EN];
    end
  end

endmodule

// >>> verilog/ptgc_pkg.sv
// Package for the PLL and timing-generator clock unit: register map, fields, reset values.
// Assumes an 8-bit register bus with byte addresses (register base plus lane 0..3).
package ptgc_pkg;

  // Register byte offsets (lane 0 of each 32-bit register)
  localparam logic [11:0] PTGC_OFS_SELECT = 12'h018;
  localparam logic [11:0] PTGC_OFS_FINE   = 12'h01c;
  localparam logic [11:0] PTGC_OFS_TGCTL  = 12'h300;
  localparam logic [11:0] PTGC_OFS_PARAM  = 12'h350;

  // Reset values (reserved ones preserved as printed)
  localparam logic [31:0] PTGC_RST_SELECT = 32'h0f150000;
  localparam logic [31:0] PTGC_RST_FINE   = 32'h00000000;
  localparam logic [31:0] PTGC_RST_TGCTL  = 32'h00000000;
  localparam logic [31:0] PTGC_RST_PARAM  = 32'h00000000;

  // Select-options fields
  localparam int PTGC_B_FB_LOW_HI  = 31;
  localparam int PTGC_B_FB_LOW_LO  = 24;
  localparam int PTGC_B_OUT_GATE   = 19;
  localparam int PTGC_B_PLL_SKIP   = 17;
  localparam int PTGC_B_PLL_SLEEP  = 16;
  localparam int PTGC_B_TG_HALT    = 13;
  localparam int PTGC_B_TG_SKIP    = 12;
  localparam int PTGC_B_TG_DIV_HI  = 11;
  localparam int PTGC_B_TG_DIV_LO  = 8;
  localparam int PTGC_B_PIN_EN     = 4;
  localparam int PTGC_B_INVERT     = 1;
  // Fine-divider fields
  localparam int PTGC_B_POST_HI    = 7;
  localparam int PTGC_B_POST_LO    = 6;
  localparam int PTGC_B_PRE_HI     = 5;
  localparam int PTGC_B_PRE_LO     = 1;
  localparam int PTGC_B_FB_HIGH    = 0;
  // Timing-generator control fields
  localparam int PTGC_B_TG_EN      = 7;
  localparam int PTGC_B_IDX_HI     = 4;
  localparam logic [4:0] PTGC_IDX_CLOCK_OUT = 5'h12;
  // Parameter-one fields
  localparam int PTGC_B_POS_INV    = 31;
  localparam int PTGC_B_PIX_INV    = 30;
  localparam int PTGC_B_AND_MODE   = 29;
  localparam int PTGC_B_DLY_HI     = 11;
  localparam int PTGC_B_DLY_LO     = 9;
  localparam int PTGC_B_TOT_HI     = 8;
  localparam int PTGC_B_TOT_LO     = 6;
  localparam int PTGC_B_NEG_HI     = 5;
  localparam int PTGC_B_NEG_LO     = 3;
  localparam int PTGC_B_POSD_HI    = 2;
  localparam int PTGC_B_POSD_LO    = 0;

  // Output delay taps in ns per code, and the clock period
  localparam int PTGC_CLK_PERIOD_NS = 5;
  localparam int PTGC_DLY_NS [8] = '{0, 1, 2, 4, 7, 10, 12, 14};
  localparam int PTGC_DLY_MAX_CYC = (14 + PTGC_CLK_PERIOD_NS - 1) / PTGC_CLK_PERIOD_NS;

  // Output divide factor per post-divider code
  localparam logic [2:0] PTGC_POST_FACTOR [4] = '{3'h1, 3'h2, 3'h3, 3'h4};

  // Pulse decode codes
  localparam logic [2:0] PTGC_PD_LOW  = 3'h0;
  localparam logic [2:0] PTGC_PD_EQ01 = 3'h5;
  localparam logic [2:0] PTGC_PD_LT8  = 3'h7;
  localparam logic [2:0] PTGC_CNT_LT8 = 3'h7;

  // Bus request carrier
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } ptgc_req_t;

  // Derived clock settings passed to the PLL model
  typedef struct packed {
    logic [8:0] fb_div;
    logic [4:0] pre_div;
    logic [1:0] post_code;
  } ptgc_pll_cfg_t;

  typedef enum logic [2:0] {
    PTGC_TG_OFF   = 3'b001,
    PTGC_TG_ARM   = 3'b010,
    PTGC_TG_RUN   = 3'b100
  } ptgc_tg_state_t;

endpackage

// >>> verilog/ptgc_pll_model.sv
// Behavioural PLL stand-in: produces enable pulses at transceiver rate * (fb+2)/((pre+2)*no).
// Assumes the transceiver clock is the module clock; fractional rate by accumulation.
module ptgc_pll_model (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Configuration
  input  wire ptgc_pkg::ptgc_pll_cfg_t cfg,
  input  wire logic                    sleep,
  input  wire logic                    skip,
  input  wire logic                    gate,
  // Output enable pulse
  output logic                         tick
);
  import ptgc_pkg::*;

  logic [15:0] acc_q;
  logic [15:0] num;
  logic [15:0] den;
  logic [16:0] sum;

  // Numerator and denominator of the frequency ratio
  always_comb begin
    num = 16'(cfg.fb_div) + 16'h0002;
    den = (16'(cfg.pre_div) + 16'h0002) * 16'(PTGC_POST_FACTOR[cfg.post_code]);
    sum = {1'b0, acc_q} + {1'b0, num};
  end

  // Fractional accumulator; a pulse per wrap, clamped to the input rate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (gate) begin
      acc_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (skip) begin
      acc_q <= 16'h0000;
      tick  <= 1'b1;
    end else if (sleep) begin
      acc_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (sum >= {1'b0, den}) begin
      acc_q <= 16'(sum - {1'b0, den});
      tick  <= 1'b1;
    end else begin
      acc_q <= sum[15:0];
      tick  <= 1'b0;
    end
  end

endmodule

// >>> verilog/ptgc_tg_divider.sv
// Timing-generator clock divider: passes enables through, or keeps one of every 2*(n+1).
// Assumes src_tick is a one-cycle enable on the module clock.
module ptgc_tg_divider #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control
  input  wire logic [W-1:0] divide,
  input  wire logic         run,
  input  wire logic         src_tick,
  // Output enable pulse
  output logic              tg_tick
);

  logic [W+1:0] cnt_q;
  logic [W+1:0] limit;

  // Count limit: 2*(n+1) source pulses per output pulse
  always_comb limit = ({2'b00, divide} + (W+2)'(1)) << 1;

  // Divider counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      tg_tick <= 1'b0;
    end else if (!run) begin
      cnt_q   <= '0;
      tg_tick <= 1'b0;
    end else if (divide == '0) begin
      cnt_q   <= '0;
      tg_tick <= src_tick;
    end else if (src_tick) begin
      tg_tick <= (cnt_q == '0);
      cnt_q   <= (cnt_q + (W+2)'(1) >= limit) ? '0 : cnt_q + (W+2)'(1);
    end else begin
      tg_tick <= 1'b0;
    end
  end

endmodule
